// ### bench/dfll_ref_model.sv
`timescale 1ns/1ps
`default_nettype none
// Reference tick and loop-clock ticks; loop rate follows the calibration words
module dfll_ref_model
  import dfll_pkg::*;
#(
  parameter int REF_PER = 200
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] coarse,
  input wire logic [7:0] fine,
  output logic ref_tick,
  output logic osc_tick
);
  logic [7:0] phase;
  logic [7:0] ticks;
  // Reference period counter, free running
  always_ff @(posedge clk) begin
    if (rst || phase == 8'(REF_PER - 1)) begin
      phase <= 8'h00;
    end else begin
      phase <= phase + 8'h01;
    end
  end
  // Rate taken early in the period, at phase 10 of 200, so a fresh calibration step is already seen
  always_ff @(posedge clk) begin
    if (rst) begin
      ticks <= 8'h00;
    end else if (phase == 8'h0A) begin
      ticks <= {1'b0, coarse, 2'b00} + {4'h0, fine[7:4]};
    end
  end
  // consumers idle: ticks only measured, never used as a clock
  assign ref_tick = !rst && phase == 8'h00;
  assign osc_tick = phase > 8'h0A && phase <= 8'h0A + ticks;
endmodule
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import dfll_pkg::*;
;
  logic clk = 0, rst = 1, en = 0, closed = 0, req_only = 1, hold = 0;
  logic mul_wr = 0, fine_wr = 0, oob_clr = 0;
  logic [15:0] mul_d = 16'h0000;
  logic [7:0] fstep = 8'h10, fine_d = 8'h00;
  logic [4:0] cstep = 5'h02;
  logic ref_tick, osc_tick, clock, flock, oob, fchg;
  logic [7:0] fine;
  logic [4:0] coarse;
  logic [15:0] mul;
  logic [16:0] diff;
  int failures = 0, n_checks = 0;
  // 25 MHz
  always #20 clk = ~clk;
  dfll_lock_calibration uut (.CLK(clk), .RST(rst), .CE(1'b1), .ENABLE(en),
    .CLOSED_LOOP(closed), .ON_REQUEST_ONLY(req_only), .STABLE_HOLD(hold),
    .MUL_WR(mul_wr), .MUL_WDATA(mul_d), .FINE_MAX_STEP(fstep),
    .COARSE_MAX_STEP(cstep), .FINE_WR(fine_wr), .FINE_WDATA(fine_d),
    .REF_TICK(ref_tick), .OSC_TICK(osc_tick), .OOB_CLR(oob_clr),
    .FINE_VALUE(fine), .COARSE_VALUE(coarse), .LOOP_MULTIPLIER(mul),
    .FREQ_DIFF(diff), .COARSE_LOCK(clock), .FINE_LOCK(flock),
    .OOB_FLAG(oob), .FINE_CHANGE(fchg));
  dfll_ref_model #(.REF_PER(200)) osc (.clk(clk), .rst(rst), .coarse(coarse),
    .fine(fine), .ref_tick(ref_tick), .osc_tick(osc_tick));
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_mul(input logic [15:0] d);
    @(posedge clk);
    mul_d <= d;
    mul_wr <= 1'b1;
    @(posedge clk);
    mul_wr <= 1'b0;
    #1;
  endtask
  task automatic wr_fine(input logic [7:0] d);
    @(posedge clk);
    fine_d <= d;
    fine_wr <= 1'b1;
    @(posedge clk);
    fine_wr <= 1'b0;
    #1;
  endtask
  // Bounded wait for fine lock; a hang ends the run
  task automatic wait_lock();
    for (int i = 0; i < 6000; i++) begin
      @(posedge clk);
      #1;
      if (flock === 1'b1) begin
        return;
      end
    end
    failures++;
    $display("BAD fine lock expected 1 seen %b", flock);
    finish_test();
  endtask
  task automatic t_reset();
    chk("fine", 17'h00080, fine);
    chk("coarse", 17'h00010, coarse);
    chk("mul", 17'h00000, mul);
    chk("flags", 17'h00000, {clock, flock, oob});
  endtask
  // Unrequested loop ignores writes, then the request is made first
  task automatic t_request();
    wr_mul(16'h0064);
    chk("mul", 17'h00000, mul);
    @(posedge clk);
    req_only <= 1'b0;
    wr_mul(16'h0064);
    chk("mul", 17'h00064, mul);
  endtask
  // Open-loop fine writes flag a possible overshoot; closed loop refuses them
  task automatic t_open();
    wr_fine(8'h5A);
    chk("fine", 17'h0005A, fine);
    chk("change", 17'h00001, fchg);
    @(posedge clk);
    closed <= 1'b1;
    wr_fine(8'h33);
    chk("fine", 17'h0005A, fine);
    @(posedge clk);
    closed <= 1'b0;
    wr_fine(8'h80);
  endtask
  // Closed-loop lock with hold set, then release the hold and let fine trim
  task automatic t_lock();
    @(posedge clk);
    hold <= 1'b1;
    closed <= 1'b1;
    en <= 1'b1;
    wait_lock();
    chk("coarse lock", 17'h00001, clock);
    chk("coarse", 17'h00016, coarse);
    chk("fine", 17'h000B0, fine);
    chk("diff", 17'h00001, diff);
    chk("oob", 17'h00000, oob);
    repeat (450) @(posedge clk);
    #1 chk("held fine", 17'h000B0, fine);
    @(posedge clk);
    hold <= 1'b0;
    repeat (4000) @(posedge clk);
    #1 chk("trim fine", 17'h000C0, fine);
    chk("diff", 17'h00000, diff);
  endtask
  // Recalibrate by toggling enable; coarse hits its floor on the way
  task automatic t_recal();
    @(posedge clk);
    en <= 1'b0;
    hold <= 1'b1;
    cstep <= 5'h10;
    wr_mul(16'h0004);
    chk("locks off", 17'h00000, {clock, flock});
    @(posedge clk);
    en <= 1'b1;
    wait_lock();
    chk("both locks", 17'h00003, {clock, flock});
    chk("coarse", 17'h00000, coarse);
    chk("fine", 17'h00050, fine);
    chk("diff", 17'h1FFFF, diff);
    chk("oob", 17'h00001, oob);
    @(posedge clk);
    oob_clr <= 1'b1;
    @(posedge clk);
    oob_clr <= 1'b0;
    #1 chk("oob clear", 17'h00000, oob);
  endtask
  // Multiplier write landing on a loop update restarts lock from one fine step off the midpoint
  task automatic t_collide();
    int i;
    logic in_win;
    i = 0;
    while (i < 400 && ref_tick !== 1'b1) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i == 400) begin
      failures++;
      $display("BAD reference tick expected 1 seen %b", ref_tick);
      finish_test();
    end
    // Tick seen now; the update cycle is two edges on, where the write lands
    wr_mul(16'h0004);
    in_win = fine >= DFLL_FINE_MID - fstep && fine <= DFLL_FINE_MID + fstep;
    chk("collide fine", 17'h00070, fine);
    chk("fine window", 17'h00001, {16'h0000, in_win});
    chk("collide locks", 17'h00000, {clock, flock});
    chk("collide mul", 17'h00004, mul);
    wait_lock();
    chk("relock coarse", 17'h00000, coarse);
    chk("relock fine", 17'h00050, fine);
    chk("relock locks", 17'h00003, {clock, flock});
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_request();
    t_open();
    t_lock();
    t_recal();
    t_collide();
    finish_test();
  end
endmodule
`default_nettype wire

// ### hw/dfll_lock_calibration.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - Multiplier write during a loop update recentres fine, steps it, restarts coarse.
// R2 - Such a collision before lock leaves fine within midpoint plus/minus fine step.
// R3 - Software waits for lock before writing the multiplier.
// R4 - Software requests the loop before configuring it; unrequested writes are ignored.
// R5 - Every fine value change is flagged as a possible frequency overshoot.
// R6 - In open loop, nobody uses the loop clock while fine is written.
// R7 - Closed loop: stable hold set, no consumers until both locks are set.
// R8 - Recalibrate by moving consumers, toggling enable, waiting fine lock, moving back.
// R9 - A frequency difference output shows deviation from the target count.
// R10 - Multiplier six gives worst case deviation of 8.33 percent.
// R11 - Multiplier five hundred gives 0.1 percent; higher multipliers are more accurate.
// R12 - Out-of-bounds flag sets when coarse or fine hits a limit while locking.
// R13 - That flag may set even though final lock values are within limits.
// R14 - Software checks both lock flags before enabling the out-of-bounds interrupt.
module dfll_lock_calibration
  import dfll_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic ENABLE,
  input wire logic CLOSED_LOOP,
  input wire logic ON_REQUEST_ONLY,
  input wire logic STABLE_HOLD,
  input wire logic MUL_WR,
  input wire logic [15:0] MUL_WDATA,
  input wire logic [7:0] FINE_MAX_STEP,
  input wire logic [4:0] COARSE_MAX_STEP,
  input wire logic FINE_WR,
  input wire logic [7:0] FINE_WDATA,
  input wire logic REF_TICK,
  input wire logic OSC_TICK,
  input wire logic OOB_CLR,
  output logic [7:0] FINE_VALUE,
  output logic [4:0] COARSE_VALUE,
  output logic [15:0] LOOP_MULTIPLIER,
  output logic [16:0] FREQ_DIFF,
  output logic COARSE_LOCK,
  output logic FINE_LOCK,
  output logic OOB_FLAG,
  output logic FINE_CHANGE
);
  dfll_meas_if mif ();
  dfll_state_t st, next_st;
  logic [7:0] next_fine;
  logic [4:0] next_coarse;
  logic next_cl, next_fl;
  logic requested, running, upd, mul_ok, fine_ok, locking;
  logic [16:0] diff;

  // Saturating step of an 8-bit calibration value
  function automatic logic [7:0] step8(input logic [7:0] v, input logic [7:0] s,
                                       input logic up, input logic [7:0] lim);
    logic [8:0] t;
    t = 9'h000;
    if (up) begin
      t = {1'b0, v} + {1'b0, s};
      step8 = (t > {1'b0, lim}) ? lim : t[7:0];
    end else begin
      step8 = (s > v) ? 8'h00 : v - s;
    end
  endfunction

  function automatic logic [16:0] mag17(input logic [16:0] d);
    mag17 = d[16] ? 17'h00000 - d : d;
  endfunction

  dfll_meas u_meas (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .run(running),
    .ref_tick(REF_TICK),
    .osc_tick(OSC_TICK),
    .mi(mif.meas)
  );

  // Request decode and update strobe
  // R4 request gating
  assign requested = ENABLE || !ON_REQUEST_ONLY;
  assign running = ENABLE && CLOSED_LOOP;
  assign upd = running && mif.done;
  assign mul_ok = MUL_WR && requested;
  assign fine_ok = FINE_WR && requested && !CLOSED_LOOP;
  assign locking = (st == DFLL_COARSE) || (st == DFLL_FINE);
  // R9 R10 R11 one tick of error is 1/multiplier, so large multipliers resolve finer
  assign diff = {1'b0, LOOP_MULTIPLIER} - {1'b0, mif.count};

  // Lock sequencer and calibration steps
  always_comb begin
    next_st = st;
    next_fine = FINE_VALUE;
    next_coarse = COARSE_VALUE;
    next_cl = COARSE_LOCK;
    next_fl = FINE_LOCK;
    if (!running) begin
      next_st = DFLL_IDLE;
      next_cl = 1'b0;
      next_fl = 1'b0;
      if (fine_ok) begin
        next_fine = FINE_WDATA;
      end
    end else if (st == DFLL_IDLE) begin
      next_st = DFLL_COARSE;
    end else if (upd && mul_ok) begin
      // R1 R2 collision recentres fine and reruns coarse
      next_fine = step8(DFLL_FINE_MID, FINE_MAX_STEP, !diff[16], DFLL_FINE_MAX);
      next_st = DFLL_COARSE;
      next_cl = 1'b0;
      next_fl = 1'b0;
    end else if (upd) begin
      unique case (st)
        DFLL_COARSE: begin
          if (mag17(diff) <= DFLL_COARSE_TOL) begin
            next_st = DFLL_FINE;
            next_cl = 1'b1;
          end else begin
            // Widened step, then cut back to the 5-bit coarse word on purpose
            next_coarse = 5'(step8({3'b000, COARSE_VALUE}, {3'b000, COARSE_MAX_STEP},
                                   !diff[16], {3'b000, DFLL_COARSE_MAX}));
          end
        end
        DFLL_FINE: begin
          if (mag17(diff) <= DFLL_FINE_TOL) begin
            next_st = DFLL_LOCKED;
            next_fl = 1'b1;
          end else begin
            next_fine = step8(FINE_VALUE, FINE_MAX_STEP, !diff[16], DFLL_FINE_MAX);
          end
        end
        DFLL_LOCKED: begin
          // R7 stable hold freezes fine once locked
          if (!STABLE_HOLD && diff != 17'h00000) begin
            next_fine = step8(FINE_VALUE, 8'h01, !diff[16], DFLL_FINE_MAX);
          end
        end
        DFLL_IDLE: begin
          next_st = DFLL_COARSE;
        end
      endcase
    end
  end

  // Sequencer state and calibration registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= DFLL_IDLE;
      FINE_VALUE <= DFLL_FINE_MID;
      COARSE_VALUE <= DFLL_COARSE_MID;
      COARSE_LOCK <= 1'b0;
      FINE_LOCK <= 1'b0;
    end else if (CE) begin
      st <= next_st;
      FINE_VALUE <= next_fine;
      COARSE_VALUE <= next_coarse;
      COARSE_LOCK <= next_cl;
      FINE_LOCK <= next_fl;
    end
  end

  // R5 overshoot warning on any fine change
  always_ff @(posedge CLK) begin
    if (RST) begin
      FINE_CHANGE <= 1'b0;
    end else if (CE) begin
      FINE_CHANGE <= next_fine != FINE_VALUE;
    end
  end

  // Multiplier; R3 is not enforced, a collision is handled as above
  always_ff @(posedge CLK) begin
    if (RST) begin
      LOOP_MULTIPLIER <= DFLL_MUL_RST;
    end else if (CE && mul_ok) begin
      LOOP_MULTIPLIER <= MUL_WDATA;
    end
  end

  // R9 difference latched per measurement
  always_ff @(posedge CLK) begin
    if (RST) begin
      FREQ_DIFF <= 17'h00000;
    end else if (CE && mif.done) begin
      FREQ_DIFF <= diff;
    end
  end

  // R12 R13 sticky limit flag, set wins over clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      OOB_FLAG <= 1'b0;
    end else if (CE) begin
      if (locking && running && (COARSE_VALUE == DFLL_COARSE_MIN ||
          COARSE_VALUE == DFLL_COARSE_MAX || FINE_VALUE == DFLL_FINE_MIN ||
          FINE_VALUE == DFLL_FINE_MAX)) begin
        OOB_FLAG <= 1'b1;
      end else if (OOB_CLR) begin
        OOB_FLAG <= 1'b0;
      end
    end
  end

  collide_restart_a: assert property (@(posedge CLK) disable iff (RST) // R1
    CE && running && st != DFLL_IDLE && upd && mul_ok |=> st == DFLL_COARSE && !COARSE_LOCK
    && !FINE_LOCK) else $error("collision did not restart coarse");
  collide_range_a: assert property (@(posedge CLK) disable iff (RST) // R2
    CE && running && st != DFLL_IDLE && upd && mul_ok |=>
    mag17({9'h000, FINE_VALUE} - {9'h000, DFLL_FINE_MID}) <= {9'h000, $past(FINE_MAX_STEP)})
    else $error("fine outside midpoint window after collision");
  unrequested_write_a: assert property (@(posedge CLK) disable iff (RST) // R4
    CE && MUL_WR && !requested |=> $stable(LOOP_MULTIPLIER))
    else $error("unrequested write took effect");
  fine_change_a: assert property (@(posedge CLK) disable iff (RST) // R5
    CE && fine_ok && FINE_WDATA != FINE_VALUE |=> FINE_CHANGE && FINE_VALUE == $past(FINE_WDATA))
    else $error("open loop fine write not flagged");
  stable_hold_a: assert property (@(posedge CLK) disable iff (RST) // R7
    CE && st == DFLL_LOCKED && running && STABLE_HOLD && !mul_ok |=> $stable(FINE_VALUE))
    else $error("fine moved under stable hold");
  disable_unlock_a: assert property (@(posedge CLK) disable iff (RST) // R8
    CE && !ENABLE |=> !COARSE_LOCK && !FINE_LOCK && st == DFLL_IDLE)
    else $error("locks survived disable");
  diff_latch_a: assert property (@(posedge CLK) disable iff (RST) // R9
    CE && mif.done |=> FREQ_DIFF == $past(diff)) else $error("difference not latched");
  oob_set_a: assert property (@(posedge CLK) disable iff (RST) // R12
    CE && running && locking && FINE_VALUE == DFLL_FINE_MAX |=> OOB_FLAG)
    else $error("limit hit without flag");
  oob_sticky_a: assert property (@(posedge CLK) disable iff (RST) // R13
    OOB_FLAG && !(CE && OOB_CLR) |=> OOB_FLAG) else $error("flag dropped without clear");
  lock_order_a: assert property (@(posedge CLK) disable iff (RST) // R14
    FINE_LOCK |-> COARSE_LOCK) else $error("fine lock without coarse lock");

  reach_lock_c: cover property (@(posedge CLK) disable iff (RST) $rose(FINE_LOCK));
  collision_c: cover property (@(posedge CLK) disable iff (RST) CE && upd && mul_ok);
  oob_c: cover property (@(posedge CLK) disable iff (RST) $rose(OOB_FLAG));
  open_write_c: cover property (@(posedge CLK) disable iff (RST) CE && fine_ok);
endmodule
`default_nettype wire

// ### hw/dfll_meas.sv
`timescale 1ns/1ps
`default_nettype none
// Counts loop-clock ticks over one reference period
module dfll_meas
  import dfll_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  input wire logic ref_tick,
  input wire logic osc_tick,
  dfll_meas_if.meas mi
);
  logic armed;
  logic [15:0] acc;

  // First reference tick only arms; a partial period would mislead the loop
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      armed <= 1'b0;
      acc <= 16'h0000;
      mi.done <= 1'b0;
      mi.count <= 16'h0000;
    end else if (ce) begin
      mi.done <= ref_tick && armed;
      if (ref_tick) begin
        armed <= 1'b1;
        mi.count <= acc;
        acc <= {15'h0000, osc_tick};
      end else if (osc_tick && acc != 16'hFFFF) begin
        acc <= acc + 16'h0001; // Saturates on a runaway loop
      end
    end
  end

  measure_done_a: assert property (@(posedge clk) disable iff (rst)
    mi.done |-> $past(ref_tick) && $past(armed) || $past(!ce))
    else $error("done without armed ref tick");
endmodule
`default_nettype wire

// ### hw/dfll_meas_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dfll_meas_if;
  logic done;
  logic [15:0] count;
  modport meas (output done, output count);
  modport ctrl (input done, input count);
endinterface
`default_nettype wire

// ### hw/dfll_pkg.sv
package dfll_pkg;
  // Calibration ranges and reset values
  localparam logic [7:0] DFLL_FINE_MID = 8'h80;
  localparam logic [7:0] DFLL_FINE_MAX = 8'hFF;
  localparam logic [7:0] DFLL_FINE_MIN = 8'h00;
  localparam logic [4:0] DFLL_COARSE_MID = 5'h10;
  localparam logic [4:0] DFLL_COARSE_MAX = 5'h1F;
  localparam logic [4:0] DFLL_COARSE_MIN = 5'h00;
  localparam logic [15:0] DFLL_MUL_RST = 16'h0000;
  // Lock windows, in loop-clock ticks per reference period
  localparam logic [16:0] DFLL_COARSE_TOL = 17'h00008;
  localparam logic [16:0] DFLL_FINE_TOL = 17'h00001;
  // Worst-case deviation, basis points, at the two quoted multipliers
  localparam int DFLL_MUL_LOW = 6;
  localparam int DFLL_DEV_LOW_BP = 833;
  localparam int DFLL_MUL_HIGH = 500;
  localparam int DFLL_DEV_HIGH_BP = 10;
  // Lock sequencer states
  typedef enum logic [3:0] {
    DFLL_IDLE = 4'b0001,
    DFLL_COARSE = 4'b0010,
    DFLL_FINE = 4'b0100,
    DFLL_LOCKED = 4'b1000
  } dfll_state_t;
endpackage
